// ### srb_pkg.sv
/*
  Package for the special register bus controller: widths, timing counts,
  request and peripheral-side structs.
  Assumes a single 25 MHz clock domain.
*/
package srb_pkg;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 10;
  localparam int unsigned FLAG_W       = 8;
  // a transfer occupies this many clocks once started
  localparam int unsigned XFER_CYCLES  = 2;
  localparam logic [1:0]  XFER_LAST    = 2'h1;
  localparam logic [7:0]  DATA_RESET   = 8'h00;
  localparam logic [9:0]  ADDR_RESET   = 10'h000;

  typedef struct packed {
    logic              write;
    logic              word;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srb_req_s;

  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } srb_bus_s;

  typedef enum logic [2:0] {
    SRB_IDLE  = 3'b001,
    SRB_WAIT  = 3'b010,
    SRB_XFER  = 3'b100
  } srb_state_e;
endpackage

// ### srb_flag_lock.sv
/*
  Read-modify-write lockout for one peripheral's status flag register.
  Assumes the CPU holds rmw_active across the whole instruction and that the
  write-back strobe arrives while it is still high.
*/
`timescale 1ns/100ps
`default_nettype none
module srb_flag_lock
  import srb_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              rmw_active,
  input  wire logic              cpu_wr,
  input  wire logic [FLAG_W-1:0] cpu_wdata,
  input  wire logic [FLAG_W-1:0] hw_set,
  output logic      [FLAG_W-1:0] flags
);
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [FLAG_W-1:0] touched_q;
  logic [FLAG_W-1:0] touched_d;
  logic              rmw_prev_q;
  wire               rmw_start = rmw_active & ~rmw_prev_q;
  wire  [FLAG_W-1:0] lock      = rmw_active ? touched_q : {FLAG_W{1'b0}};

  genvar i;
  generate
    for (i = 0; i < FLAG_W; i++) begin : g_bit
      // a hardware set in the write-back cycle wins over the cpu value
      assign flags_d[i] = hw_set[i] ? 1'b1 :
                          (cpu_wr & ~lock[i]) ? cpu_wdata[i] : flags_q[i];
      // record restarts at the start of each operation; idle it is unused
      assign touched_d[i] = rmw_start ? hw_set[i] :
                            rmw_active ? (touched_q[i] | hw_set[i]) : 1'b0;
    end
  endgenerate

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      flags_q    <= DATA_RESET;
      touched_q  <= DATA_RESET;
      rmw_prev_q <= 1'b0;
    end else begin
      flags_q    <= flags_d;
      touched_q  <= touched_d;
      rmw_prev_q <= rmw_active;
    end
  end

  assign flags = flags_q;
endmodule
`default_nettype wire

// ### srb_ctrl.sv
/*
  Special register bus controller: takes byte requests from the CPU core,
  runs each as a two-clock transfer on the 8-bit register bus, lets the CPU
  continue after a posted write, and holds one peripheral flag register with
  read-modify-write lockout.
  Timing, counted in rising edges from the edge t0 at which a request is
  taken (req high, busy low, word clear):
    slot_free high at t0: strobes, address and busy stand from t0 on;
      the edge t0+2 ends the last transfer clock, drops strobes and busy,
      pulses done for one clock and captures read data
    slot_free low at t0: one wait clock first, every later step moves one
      edge on, so the transfer ends at t0+3
    next request: may be taken at the first edge that sees busy low
    word request: no transfer, word_err pulses for the clock after t0
  Request to completion is therefore two or three clocks, of which exactly
  two carry strobes.
  Writes to flag_addr land in the internal flag register at the last
  transfer clock and are also seen on the bus; reads from flag_addr return
  the internal register, not the bus data.
  The busy output is the CPU's stall signal: a request raised while it is
  high is not taken and must be held or repeated after it falls.
  Address and write data stay on the bus between transfers; only the
  strobes say whether they mean anything.
  Assumes the CPU raises req only when busy is low and holds rmw_active for
  the whole read-modify-write instruction.
*/
// Overview of operation
// - every register access, status word included, uses bus
// - accepted writes complete while CPU moves on
// - CPU stalls new request while controller busy
// - each transfer lasts exactly two clocks
// - request to completion takes two or three clocks
// - bus is byte wide; word requests refused
// - peripheral blocks write-back only of flags it set
// - lockout ends when the operation completes
`timescale 1ns/100ps
`default_nettype none
module srb_ctrl
  import srb_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 req,
  input  wire srb_pkg::srb_req_s    req_info,
  input  wire logic                 rmw_active,
  input  wire logic                 slot_free,
  input  wire logic [DATA_W-1:0]    bus_rdata,
  input  wire logic [FLAG_W-1:0]    hw_flag_set,
  input  wire logic [ADDR_W-1:0]    flag_addr,
  output logic                      busy,
  output logic                      done,
  output logic                      word_err,
  output logic [DATA_W-1:0]         rdata,
  output srb_pkg::srb_bus_s         bus,
  output logic [FLAG_W-1:0]         flag_reg
);
  import srb_pkg::*;

  srb_state_e        state_q;
  srb_state_e        state_d;
  srb_req_s          held_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              busy_q;
  logic              busy_d;
  logic              done_q;
  logic              werr_q;
  logic [DATA_W-1:0] rdata_q;
  logic              rd_q;
  logic              wr_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [FLAG_W-1:0] flag_rd;

  wire accept     = req & ~busy_q & ~req_info.word;
  wire refuse     = req & ~busy_q & req_info.word;
  wire go_now     = accept & slot_free;
  wire wait_go    = (state_q == SRB_WAIT);
  wire start      = go_now | wait_go;
  wire in_xfer    = (state_q == SRB_XFER);
  wire last_clk   = in_xfer & (cnt_q == XFER_LAST);
  wire [ADDR_W-1:0] cur_addr  = go_now ? req_info.addr : held_q.addr;
  wire              cur_write = go_now ? req_info.write : held_q.write;
  wire [DATA_W-1:0] cur_wdata = go_now ? req_info.wdata : held_q.wdata;
  wire hit_flag   = (held_q.addr == flag_addr);
  wire flag_wr    = last_clk & held_q.write & hit_flag;
  wire [DATA_W-1:0] rd_src = hit_flag ? flag_rd : bus_rdata;

  // start loads the counter with zero and it only runs inside a transfer, so it reads zero on each first clock
  assign cnt_d  = start   ? 2'h0 :
                  in_xfer ? (cnt_q + 2'h1) : cnt_q;
  // accept and last_clk never meet: accept needs busy low, last_clk busy high
  assign busy_d = accept   ? 1'b1 :
                  last_clk ? 1'b0 : busy_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SRB_IDLE: begin
        if (go_now) begin
          state_d = SRB_XFER;
        end else if (accept) begin
          state_d = SRB_WAIT;
        end
      end
      // the one clock of start uncertainty while the slot is taken
      SRB_WAIT: begin
        state_d = SRB_XFER;
      end
      SRB_XFER: begin
        if (last_clk) begin
          state_d = SRB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= SRB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // request is latched so the CPU may drop it and go on after a write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      held_q <= '0;
    end else if (accept) begin
      held_q <= req_info;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
    end
  end

  // bus strobes stand for both transfer clocks and fall with the last one
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (start) begin
      rd_q <= ~cur_write;
      wr_q <= cur_write;
    end else if (last_clk) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
    end
  end

  // no clear between transfers: saves toggling the wide fields every idle clock
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      addr_q  <= ADDR_RESET;
      wdata_q <= DATA_RESET;
    end else if (start) begin
      addr_q  <= cur_addr;
      wdata_q <= cur_wdata;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= last_clk;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      werr_q <= 1'b0;
    end else begin
      werr_q <= refuse;
    end
  end

  // read data holds until the next read so a slow CPU may still fetch it
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rdata_q <= DATA_RESET;
    end else if (last_clk & ~held_q.write) begin
      rdata_q <= rd_src;
    end
  end

  // lockout sits in its own module so every flag register can reuse it
  srb_flag_lock u_flag_lock (
    .mclk       (mclk),
    .reset      (reset),
    .rmw_active (rmw_active),
    .cpu_wr     (flag_wr),
    .cpu_wdata  (held_q.wdata),
    .hw_set     (hw_flag_set),
    .flags      (flag_rd)
  );

  assign busy     = busy_q;
  assign done     = done_q;
  assign word_err = werr_q;
  assign rdata    = rdata_q;
  assign bus      = '{rd: rd_q, wr: wr_q, addr: addr_q, wdata: wdata_q};
  assign flag_reg = flag_rd;
endmodule
`default_nettype wire

// ### srb_ctrl_assertions.sv
/*
  Checker on the srb_ctrl ports.
  Assumes it is bound from the bench top and sees ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module srb_ctrl_assertions
  import srb_pkg::*;
(
  input wire logic              mclk,
  input wire logic              reset,
  input wire logic              req,
  input wire srb_pkg::srb_req_s req_info,
  input wire logic              slot_free,
  input wire logic              rmw_active,
  input wire logic [FLAG_W-1:0] hw_flag_set,
  input wire logic              busy,
  input wire logic              done,
  input wire logic              word_err,
  input wire srb_pkg::srb_bus_s bus,
  input wire logic [FLAG_W-1:0] flag_reg
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic              take;
  logic              strb;
  logic [FLAG_W-1:0] lock_q;
  assign take = req && !busy && !req_info.word;
  assign strb = bus.rd || bus.wr;
  // flags raised by hardware since the lockout began
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) lock_q <= 8'h00;
    else lock_q <= rmw_active ? (lock_q | hw_flag_set) : 8'h00;
  end
  sequence s_hold;
    strb [*2] ##1 !strb;
  endsequence
  a_start_fast: assert property (take && slot_free |=> strb)
    else $error("strobe not one clock after take");
  a_start_slow: assert property (take && !slot_free |=> !strb ##1 s_hold)
    else $error("delayed start wrong");
  a_xfer_len: assert property ($rose(strb) |-> s_hold)
    else $error("transfer not two clocks");
  a_done_time: assert property (take |-> ##[3:4] done)
    else $error("done late");
  a_busy_span: assert property (take |=> busy [*2])
    else $error("busy dropped early");
  a_word_refuse: assert property (req && !busy && req_info.word |=> word_err && !strb)
    else $error("word request not refused");
  a_stall_only: assert property ($rose(strb) |-> $past(take) || $past(take, 2))
    else $error("transfer without take");
  a_flag_lock: assert property (rmw_active |-> (flag_reg & lock_q) == lock_q)
    else $error("locked flag lost");
endmodule
`default_nettype wire

// ### srb_periph_model.sv
/*
  Peripheral register stand-in: 16-byte store on the register bus.
  Assumes bus_rdata is sampled on the last strobe clock.
*/
`timescale 1ns/100ps
`default_nettype none
module srb_periph_model
  import srb_pkg::*;
(
  input  wire logic              mclk,
  input  wire srb_pkg::srb_bus_s bus,
  output logic [DATA_W-1:0]      bus_rdata
);
  logic [DATA_W-1:0] mem [16];
  logic [DATA_W-1:0] last_q;
  // idle data is inverted so a stale sample never matches
  assign bus_rdata = bus.rd ? mem[bus.addr[3:0]] : ~last_q;
  always_ff @(posedge mclk) begin
    if (bus.wr) mem[bus.addr[3:0]] <= bus.wdata;
    if (bus.rd) last_q <= bus_rdata;
  end
endmodule
`default_nettype wire

// ### srb_ctrl_tb_top.sv
/*
  Bench for srb_ctrl with the peripheral model.
  Assumes srb_pkg and the checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module srb_ctrl_tb_top;
  import srb_pkg::*;
  localparam logic [9:0] FLAG_A = 10'h3F0;
  logic       mclk, reset, req, rmw_active, slot_free, busy, done, word_err;
  srb_req_s   req_info;
  srb_bus_s   bus;
  logic [7:0] bus_rdata, hw_flag_set, rdata, flag_reg;
  int         n_fail, n_tests;
  srb_ctrl u_srb_ctrl (.mclk(mclk), .reset(reset), .req(req), .req_info(req_info),
    .rmw_active(rmw_active), .slot_free(slot_free), .bus_rdata(bus_rdata),
    .hw_flag_set(hw_flag_set), .flag_addr(FLAG_A), .busy(busy), .done(done),
    .word_err(word_err), .rdata(rdata), .bus(bus), .flag_reg(flag_reg));
  srb_periph_model u_srb_periph_model (.mclk(mclk), .bus(bus), .bus_rdata(bus_rdata));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic xfer(input logic w, wd, sf, input logic [9:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    req <= 1'b1;
    req_info <= '{w, wd, a, d};
    slot_free <= sf;
    @(posedge mclk);
    req <= 1'b0;
    #1;
    while (!(done === 1'b1 || word_err === 1'b1) && n < 10) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n == 10) begin
      n_fail++;
      close_out;
    end
    if (!wd) chk(16'(n), sf ? 16'h0002 : 16'h0003);
  endtask
  task automatic s_rw;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 1'b0, i[0], 10'(i), 8'hA0 + 8'(i));
    end
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 1'b0, !i[0], 10'(i), 8'h00);
      chk(rdata, 8'hA0 + 8'(i));
    end
    xfer(1'b1, 1'b1, 1'b1, 10'h001, 8'h5A);
    chk(word_err, 1'b1);
    xfer(1'b0, 1'b0, 1'b1, 10'h001, 8'h00);
    chk(rdata, 8'hA1);
  endtask
  // second request held while busy must be ignored
  task automatic s_stall;
    @(posedge mclk);
    req <= 1'b1;
    req_info <= '{1'b1, 1'b0, 10'h002, 8'h11};
    @(posedge mclk);
    req_info <= '{1'b1, 1'b0, 10'h003, 8'h22};
    @(posedge mclk);
    req <= 1'b0;
    repeat (4) @(posedge mclk);
    xfer(1'b0, 1'b0, 1'b1, 10'h002, 8'h00);
    chk(rdata, 8'h11);
    xfer(1'b0, 1'b0, 1'b0, 10'h003, 8'h00);
    chk(rdata, 8'hA3);
  endtask
  task automatic s_rmw;
    xfer(1'b1, 1'b0, 1'b1, FLAG_A, 8'h00);
    @(posedge mclk);
    rmw_active <= 1'b1;
    @(posedge mclk);
    hw_flag_set <= 8'h05;
    @(posedge mclk);
    hw_flag_set <= 8'h00;
    xfer(1'b1, 1'b0, 1'b0, FLAG_A, 8'hF0);
    chk(flag_reg, 8'hF5);
    @(posedge mclk);
    rmw_active <= 1'b0;
    xfer(1'b1, 1'b0, 1'b1, FLAG_A, 8'h00);
    chk(flag_reg, 8'h00);
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    {n_fail, n_tests} = '0;
    {reset, req, rmw_active, slot_free, req_info, hw_flag_set} = '1;
    {req, rmw_active, req_info, hw_flag_set} = '0;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    #1;
    chk(busy, 1'b0);
    chk(flag_reg, 8'h00);
    s_rw;
    s_stall;
    s_rmw;
    close_out;
  end
endmodule
bind srb_ctrl srb_ctrl_assertions u_srb_ctrl_assertions (.mclk(mclk), .reset(reset),
  .req(req), .req_info(req_info), .slot_free(slot_free), .rmw_active(rmw_active),
  .hw_flag_set(hw_flag_set), .busy(busy), .done(done), .word_err(word_err),
  .bus(bus), .flag_reg(flag_reg));
`default_nettype wire
